// [rtl/controller_end.sv]
// host end: break and bit writer, response reader, line and clock holds
`timescale 1ns/1ns
`include "link_cfg.svh"
module controller_end #(
    parameter int READ_TIMEOUT_US = `READ_TIMEOUT_US,
    parameter int DATA_W = `BYTE_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    wire_if.host link,
    input wire logic i_start,
    input wire logic i_with_break,
    input wire logic i_read,
    input wire logic [DATA_W-1:0] i_wr_data,
    output logic o_ready,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_timeout,
    input wire logic i_hold_line,
    input wire logic i_hold_scl
);
    localparam int TW = `TIMER_W;
    localparam int BW = $clog2(DATA_W);

    link_types_pkg::host_state_t state_reg;
    link_types_pkg::host_state_t state_next;
    logic [`DIV_W-1:0] div_reg;
    logic [`DIV_W-1:0] div_next;
    logic tick;
    logic [TW-1:0] us_reg;
    logic [TW-1:0] us_next;
    logic [BW-1:0] bits_reg;
    logic [BW-1:0] bits_next;
    logic [DATA_W-1:0] shift_reg;
    logic [DATA_W-1:0] shift_next;
    logic [DATA_W-1:0] rd_data_reg;
    logic [DATA_W-1:0] rd_data_next;
    logic read_reg;
    logic read_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic timeout_reg;
    logic timeout_next;
    logic oe_reg;
    logic oe_next;
    logic scl_oe_reg;
    logic [TW-1:0] pulse_len;
    logic rd_bit;

    always_comb begin
        tick = (div_reg == `DIV_W'(`TICK_DIV - 1));
        div_next = tick ? '0 : div_reg + `DIV_W'(1);
        pulse_len = shift_reg[0] ? `TICKS(`HOST_ONE_PULSE_US)
                                 : `TICKS(`HOST_ZERO_PULSE_US);
        rd_bit = (us_reg < `TICKS(`SAMPLE_POINT_US));
    end

    always_comb begin
        state_next = state_reg;
        us_next = us_reg;
        if (tick && us_reg != '1) begin
            us_next = us_reg + TW'(1);
        end
        bits_next = bits_reg;
        shift_next = shift_reg;
        rd_data_next = rd_data_reg;
        read_next = read_reg;
        rd_valid_next = 1'b0;
        timeout_next = 1'b0;
        case (state_reg)
            link_types_pkg::H_IDLE: begin
                us_next = '0;
                if (i_start) begin
                    shift_next = i_wr_data;
                    read_next = i_read;
                    bits_next = '0;
                    state_next = i_with_break ? link_types_pkg::H_BRK_LOW
                                              : link_types_pkg::H_WR_LOW;
                end
            end
            link_types_pkg::H_BRK_LOW: begin
                // strictly above the minimum absorbs tick phase
                if (us_reg > `TICKS(`BREAK_LOW_US)) begin
                    us_next = '0;
                    state_next = link_types_pkg::H_BRK_REC;
                end
            end
            link_types_pkg::H_BRK_REC: begin
                if (us_reg > `TICKS(`BREAK_RECOVERY_US)) begin
                    us_next = '0;
                    state_next = link_types_pkg::H_WR_LOW;
                end
            end
            link_types_pkg::H_WR_LOW: begin
                if (us_reg >= pulse_len) begin
                    state_next = link_types_pkg::H_WR_HIGH;
                end
            end
            link_types_pkg::H_WR_HIGH: begin
                if (us_reg > `TICKS(`HOST_BIT_SLOT_US)) begin
                    us_next = '0;
                    shift_next = {1'b0, shift_reg[DATA_W-1:1]};
                    bits_next = bits_reg + BW'(1);
                    if (bits_reg != BW'(DATA_W - 1)) begin
                        state_next = link_types_pkg::H_WR_LOW;
                    end else if (read_reg) begin
                        state_next = link_types_pkg::H_RD_WAIT;
                    end else begin
                        state_next = link_types_pkg::H_IDLE;
                    end
                end
            end
            link_types_pkg::H_RD_WAIT: begin
                // response delay varies, so wait up to the timeout
                if (!link.line) begin
                    us_next = '0;
                    state_next = link_types_pkg::H_RD_LOW;
                end else if (us_reg > TW'(READ_TIMEOUT_US)) begin
                    timeout_next = 1'b1;
                    state_next = link_types_pkg::H_IDLE;
                end
            end
            link_types_pkg::H_RD_LOW: begin
                if (link.line) begin
                    us_next = '0;
                    shift_next = {rd_bit, shift_reg[DATA_W-1:1]};
                    bits_next = bits_reg + BW'(1);
                    if (bits_reg == BW'(DATA_W - 1)) begin
                        rd_data_next = {rd_bit, shift_reg[DATA_W-1:1]};
                        rd_valid_next = 1'b1;
                        state_next = link_types_pkg::H_TURN;
                    end else begin
                        state_next = link_types_pkg::H_RD_WAIT;
                    end
                end
            end
            link_types_pkg::H_TURN: begin
                if (us_reg > `TICKS(`HOST_TURNAROUND_DELAY_US)) begin
                    state_next = link_types_pkg::H_IDLE;
                end
            end
            default: begin
                state_next = link_types_pkg::H_IDLE;
            end
        endcase
        if (i_hold_line) begin
            state_next = link_types_pkg::H_IDLE;
        end
        oe_next = i_hold_line
                  || state_next == link_types_pkg::H_BRK_LOW
                  || state_next == link_types_pkg::H_WR_LOW;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= link_types_pkg::H_IDLE;
            div_reg <= '0;
            us_reg <= '0;
            bits_reg <= '0;
            shift_reg <= '0;
            rd_data_reg <= '0;
            read_reg <= 1'b0;
            rd_valid_reg <= 1'b0;
            timeout_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            div_reg <= div_next;
            us_reg <= us_next;
            bits_reg <= bits_next;
            shift_reg <= shift_next;
            rd_data_reg <= rd_data_next;
            read_reg <= read_next;
            rd_valid_reg <= rd_valid_next;
            timeout_reg <= timeout_next;
            oe_reg <= oe_next;
            scl_oe_reg <= i_hold_scl;
        end
    end

    // serial clock is only held low here; its rate is the caller's
    assign link.host_out = 1'b0;
    assign link.host_oe = oe_reg;
    assign link.scl_out = 1'b0;
    assign link.scl_oe = scl_oe_reg;
    assign o_ready = (state_reg == link_types_pkg::H_IDLE) && !i_hold_line;
    assign o_rd_data = rd_data_reg;
    assign o_rd_valid = rd_valid_reg;
    assign o_timeout = timeout_reg;
endmodule

// [rtl/link_cfg.svh]
// timing constants for the single-wire host link and bus-reset watchers
`ifndef LINK_CFG_SVH
`define LINK_CFG_SVH

`define CLK_PERIOD_NS 50
`define TICK_NS 1000
`define TICK_DIV (`TICK_NS / `CLK_PERIOD_NS)
`define DIV_W 5
`define TIMER_W 16
`define TICKS(us) 16'((us) * 1000 / `TICK_NS)

`define BREAK_LOW_US 190
`define BREAK_RECOVERY_US 40
`define HOST_ONE_PULSE_US 10
`define HOST_ZERO_PULSE_US 110
`define HOST_ZERO_MAX_US 145
`define HOST_BIT_SLOT_US 200
`define DEVICE_ONE_PULSE_US 40
`define DEVICE_ZERO_PULSE_US 110
`define DEVICE_BIT_SLOT_US 205
`define DEVICE_RESPONSE_DELAY_US 190
`define HOST_TURNAROUND_DELAY_US 210
`define SAMPLE_POINT_US 65
`define READ_TIMEOUT_US 20000
`define BUS_RESET_US 2000000
`define RESET_CNT_W 21
`define BYTE_W 8
`define BIT_CNT_W 3
`endif

// [rtl/link_types_pkg.sv]
// state types for both ends of the single-wire link
package link_types_pkg;
    typedef enum logic [1:0] {
        D_RX,
        D_TX_LOW,
        D_TX_HIGH
    } dev_state_t;

    typedef enum logic [2:0] {
        H_IDLE,
        H_BRK_LOW,
        H_BRK_REC,
        H_WR_LOW,
        H_WR_HIGH,
        H_RD_WAIT,
        H_RD_LOW,
        H_TURN
    } host_state_t;
endpackage

// [rtl/responder_end.sv]
// device end: bit receiver, timed responder and bus-reset watchers
`timescale 1ns/1ns
`include "link_cfg.svh"
module responder_end #(
    parameter int BUS_RESET_US = `BUS_RESET_US,
    parameter int DATA_W = `BYTE_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    wire_if.device link,
    output logic [DATA_W-1:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_break_seen,
    input wire logic [DATA_W-1:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic o_tx_busy,
    output logic o_link_reset,
    output logic o_serial_reset
);
    localparam int CW = `RESET_CNT_W;
    localparam int TW = `TIMER_W;
    localparam int BW = $clog2(DATA_W);

    // ****************************************
    // microsecond time base and reset watchers
    // ****************************************
    logic [`DIV_W-1:0] div_reg;
    logic [`DIV_W-1:0] div_next;
    logic tick;
    logic [1:0] low_in;
    logic [1:0] fire_reg;
    logic dev_oe_reg;

    always_comb begin
        tick = (div_reg == `DIV_W'(`TICK_DIV - 1));
        div_next = tick ? '0 : div_reg + `DIV_W'(1);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    // own pulses are not the host holding the line
    assign low_in[0] = ~link.line & ~dev_oe_reg;
    assign low_in[1] = ~link.scl;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_watch
            logic [CW-1:0] hold_reg;
            logic [CW-1:0] hold_next;
            logic fire_next;

            always_comb begin
                hold_next = hold_reg;
                fire_next = 1'b0;
                if (!low_in[g]) begin
                    hold_next = '0;
                end else if (tick && hold_reg != CW'(BUS_RESET_US)) begin
                    hold_next = hold_reg + CW'(1);
                    // one pulse per hold, however long it lasts
                    fire_next = (hold_reg == CW'(BUS_RESET_US - 1));
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    hold_reg <= '0;
                    fire_reg[g] <= 1'b0;
                end else begin
                    hold_reg <= hold_next;
                    fire_reg[g] <= fire_next;
                end
            end
        end
    endgenerate

    assign o_link_reset = fire_reg[0];
    assign o_serial_reset = fire_reg[1];

    // ****************************************
    // bit engine
    // ****************************************
    link_types_pkg::dev_state_t state_reg;
    link_types_pkg::dev_state_t state_next;
    logic [TW-1:0] us_reg;
    logic [TW-1:0] us_next;
    logic [TW-1:0] low_reg;
    logic [TW-1:0] low_next;
    logic line_q_reg;
    logic [BW-1:0] bits_reg;
    logic [BW-1:0] bits_next;
    logic [DATA_W-1:0] shift_reg;
    logic [DATA_W-1:0] shift_next;
    logic [DATA_W-1:0] rx_data_reg;
    logic [DATA_W-1:0] rx_data_next;
    logic rx_valid_reg;
    logic rx_valid_next;
    logic break_reg;
    logic break_next;
    logic dev_oe_next;
    logic rise;
    logic rx_bit;
    logic tx_ready;
    logic [TW-1:0] pulse_len;

    always_comb begin
        rise = ~line_q_reg & link.line;
        // shorter than the sample point means the line was high there
        rx_bit = (low_reg < `TICKS(`SAMPLE_POINT_US));
        pulse_len = shift_reg[0] ? `TICKS(`DEVICE_ONE_PULSE_US)
                                 : `TICKS(`DEVICE_ZERO_PULSE_US);
        tx_ready = (state_reg == link_types_pkg::D_RX) && link.line
                   && line_q_reg
                   && (us_reg > `TICKS(`DEVICE_RESPONSE_DELAY_US));
    end

    always_comb begin
        state_next = state_reg;
        us_next = us_reg;
        if (tick && us_reg != '1) begin
            us_next = us_reg + TW'(1);
        end
        low_next = low_reg;
        bits_next = bits_reg;
        shift_next = shift_reg;
        rx_data_next = rx_data_reg;
        rx_valid_next = 1'b0;
        break_next = 1'b0;
        case (state_reg)
            link_types_pkg::D_RX: begin
                if (!link.line) begin
                    if (tick && low_reg != '1) begin
                        low_next = low_reg + TW'(1);
                    end
                    // response delay counts from the host's last release
                    us_next = '0;
                end else if (rise) begin
                    low_next = '0;
                    if (low_reg > `TICKS(`HOST_ZERO_MAX_US)) begin
                        bits_next = '0;
                        break_next = 1'b1;
                    end else begin
                        shift_next = {rx_bit, shift_reg[DATA_W-1:1]};
                        bits_next = bits_reg + BW'(1);
                        if (bits_reg == BW'(DATA_W - 1)) begin
                            rx_data_next = {rx_bit, shift_reg[DATA_W-1:1]};
                            rx_valid_next = 1'b1;
                        end
                    end
                end else if (tx_ready && i_tx_valid) begin
                    shift_next = i_tx_data;
                    bits_next = '0;
                    us_next = '0;
                    state_next = link_types_pkg::D_TX_LOW;
                end
            end
            link_types_pkg::D_TX_LOW: begin
                if (us_reg >= pulse_len) begin
                    state_next = link_types_pkg::D_TX_HIGH;
                end
            end
            link_types_pkg::D_TX_HIGH: begin
                // slot runs from our own falling edge
                if (us_reg >= `TICKS(`DEVICE_BIT_SLOT_US)) begin
                    us_next = '0;
                    if (bits_reg == BW'(DATA_W - 1)) begin
                        bits_next = '0;
                        low_next = '0;
                        state_next = link_types_pkg::D_RX;
                    end else begin
                        bits_next = bits_reg + BW'(1);
                        shift_next = {1'b0, shift_reg[DATA_W-1:1]};
                        state_next = link_types_pkg::D_TX_LOW;
                    end
                end
            end
            default: begin
                state_next = link_types_pkg::D_RX;
            end
        endcase
        if (fire_reg[0]) begin
            // low count kept so the release still reads as a break
            state_next = link_types_pkg::D_RX;
            bits_next = '0;
            us_next = '0;
        end
        dev_oe_next = (state_next == link_types_pkg::D_TX_LOW);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= link_types_pkg::D_RX;
            us_reg <= '0;
            low_reg <= '0;
            line_q_reg <= 1'b1;
            bits_reg <= '0;
            shift_reg <= '0;
            rx_data_reg <= '0;
            rx_valid_reg <= 1'b0;
            break_reg <= 1'b0;
            dev_oe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            us_reg <= us_next;
            low_reg <= low_next;
            line_q_reg <= link.line;
            bits_reg <= bits_next;
            shift_reg <= shift_next;
            rx_data_reg <= rx_data_next;
            rx_valid_reg <= rx_valid_next;
            break_reg <= break_next;
            dev_oe_reg <= dev_oe_next;
        end
    end

    // open drain: only ever pulls low
    assign link.dev_out = 1'b0;
    assign link.dev_oe = dev_oe_reg;
    assign o_rx_data = rx_data_reg;
    assign o_rx_valid = rx_valid_reg;
    assign o_break_seen = break_reg;
    assign o_tx_ready = tx_ready;
    assign o_tx_busy = (state_reg != link_types_pkg::D_RX);
endmodule

// [rtl/wire_if.sv]
// open-drain single wire and serial clock shared by host and device
`timescale 1ns/1ns
interface wire_if;
    logic host_out;
    logic host_oe;
    logic dev_out;
    logic dev_oe;
    logic scl_out;
    logic scl_oe;
    logic line;
    logic scl;

    // pulled high; low whenever an enabled driver pulls low
    assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));
    assign scl = ~(scl_oe & ~scl_out);

    modport device (
        input line,
        input scl,
        output dev_out,
        output dev_oe
    );

    modport host (
        input line,
        output host_out,
        output host_oe,
        output scl_out,
        output scl_oe
    );
endinterface

// [tb/link_properties.sv]
// wire-level timing checks for the single-wire link
`timescale 1ns/1ns
module link_properties (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_host_oe,
    input wire logic i_dev_oe
);
    localparam int US = 20;
    localparam int SAT = 100000;
    wire logic host_oe = i_host_oe;
    wire logic dev_oe = i_dev_oe;
    int host_lo;
    int host_hi;
    int host_rr;
    int dev_lo;
    int dev_rr;
    int dev_fall;
    int dev_bits;
    logic brk_prev;

    // ****
    // helper counters
    // ****
    // counters saturate so long idle spans never wrap into a short one
    function automatic int inc(input int v);
        return (v >= SAT) ? v : v + 1;
    endfunction

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            host_lo <= 0;
            host_hi <= SAT;
            host_rr <= SAT;
            dev_lo <= 0;
            dev_rr <= SAT;
            dev_fall <= SAT;
            dev_bits <= 0;
            brk_prev <= 1'b0;
        end else begin
            host_lo <= host_oe ? inc(host_lo) : 0;
            host_hi <= host_oe ? 0 : inc(host_hi);
            host_rr <= $rose(host_oe) ? 1 : inc(host_rr);
            dev_lo <= dev_oe ? inc(dev_lo) : 0;
            dev_rr <= $rose(dev_oe) ? 1 : inc(dev_rr);
            dev_fall <= dev_oe ? 0 : inc(dev_fall);
            if ($fell(host_oe)) brk_prev <= (host_lo >= 190 * US);
            if ($rose(host_oe)) dev_bits <= 0;
            else if ($rose(dev_oe)) dev_bits <= dev_bits + 1;
        end
    end

    // ****
    // properties
    // ****
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_dev_pulse;
        $fell(dev_oe) |-> (dev_lo >= 32 * US && dev_lo <= 50 * US) ||
            (dev_lo >= 80 * US && dev_lo <= 145 * US);
    endproperty
    a_dev_pulse: assert property (p_dev_pulse)
        else $error("device low pulse out of range");

    // a rise more than one slot after the last starts a new response
    property p_dev_slot;
        $rose(dev_oe) && dev_rr <= 250 * US |-> dev_rr >= 190 * US;
    endproperty
    a_dev_slot: assert property (p_dev_slot)
        else $error("device bit slot too short");

    property p_resp_delay;
        $rose(dev_oe) && dev_rr > 250 * US |-> host_hi > 190 * US;
    endproperty
    a_resp_delay: assert property (p_resp_delay)
        else $error("device response started too early");

    property p_dev_count;
        $rose(host_oe) |-> dev_bits == 0 || dev_bits == 8;
    endproperty
    a_dev_count: assert property (p_dev_count)
        else $error("response not eight bits");

    property p_host_pulse;
        $fell(host_oe) |-> (host_lo >= 10 && host_lo <= 50 * US) ||
            (host_lo >= 86 * US && host_lo <= 145 * US) ||
            host_lo >= 190 * US;
    endproperty
    a_host_pulse: assert property (p_host_pulse)
        else $error("host low pulse out of range");

    property p_brk_rec;
        $rose(host_oe) && brk_prev |-> host_hi >= 40 * US;
    endproperty
    a_brk_rec: assert property (p_brk_rec)
        else $error("break recovery too short");

    property p_host_slot;
        $rose(host_oe) |-> host_rr >= 190 * US;
    endproperty
    a_host_slot: assert property (p_host_slot)
        else $error("host bit slot too short");

    property p_turnaround;
        $rose(host_oe) |-> dev_fall >= 210 * US;
    endproperty
    a_turnaround: assert property (p_turnaround)
        else $error("host drove too soon after response");

    c_break: cover property ($fell(host_oe) && host_lo >= 190 * US);
    c_response: cover property ($rose(dev_oe) && dev_rr > 250 * US);
    c_dev_zero: cover property ($fell(dev_oe) && dev_lo >= 80 * US);
endmodule

// [tb/one_wire_host_link_timing_test.sv]
// testbench joining both link ends across one wire interface
`timescale 1ns/1ns
module one_wire_host_link_timing_test;
    localparam int BUS_US = 300;
    localparam int RST_CYC = BUS_US * 20;
    logic i_clk;
    logic i_rst;
    logic i_start, i_with_break, i_read, i_hold_line, i_hold_scl;
    logic [7:0] i_wr_data, i_tx_data;
    logic i_tx_valid;
    logic [7:0] o_rx_data, o_rd_data;
    logic o_rx_valid, o_break_seen, o_tx_ready, o_tx_busy;
    logic o_link_reset, o_serial_reset, o_ready, o_rd_valid, o_timeout;
    logic [15:0] rx_cnt, brk_cnt, lrst_cnt, srst_cnt, rd_cnt, tm_cnt;
    logic [15:0] rd_last;
    int mismatches = 0;
    int check_count = 0;

    wire_if link_w();
    responder_end #(.BUS_RESET_US(BUS_US)) responder_end_i (
        .i_clk(i_clk), .i_rst(i_rst), .link(link_w),
        .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid),
        .o_break_seen(o_break_seen), .i_tx_data(i_tx_data),
        .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
        .o_tx_busy(o_tx_busy), .o_link_reset(o_link_reset),
        .o_serial_reset(o_serial_reset));
    controller_end #(.READ_TIMEOUT_US(1000)) controller_end_i (
        .i_clk(i_clk), .i_rst(i_rst), .link(link_w),
        .i_start(i_start), .i_with_break(i_with_break),
        .i_read(i_read), .i_wr_data(i_wr_data), .o_ready(o_ready),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
        .o_timeout(o_timeout), .i_hold_line(i_hold_line),
        .i_hold_scl(i_hold_scl));
    link_properties link_properties_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_host_oe(link_w.host_oe), .i_dev_oe(link_w.dev_oe));

    // ****
    // clock, monitor, checking
    // ****
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // one-cycle pulses are counted here so no scenario can miss one
    always @(posedge i_clk) begin
        if (i_rst) begin
            {rx_cnt, brk_cnt, lrst_cnt} <= '0;
            {srst_cnt, rd_cnt, tm_cnt, rd_last} <= '0;
        end else begin
            if (o_rx_valid === 1'b1) rx_cnt <= rx_cnt + 16'h0001;
            if (o_break_seen === 1'b1) brk_cnt <= brk_cnt + 16'h0001;
            if (o_link_reset === 1'b1) lrst_cnt <= lrst_cnt + 16'h0001;
            if (o_serial_reset === 1'b1) srst_cnt <= srst_cnt + 16'h0001;
            if (o_timeout === 1'b1) tm_cnt <= tm_cnt + 16'h0001;
            if (o_rd_valid === 1'b1) begin
                rd_cnt <= rd_cnt + 16'h0001;
                rd_last <= {8'h00, o_rd_data};
            end
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task automatic run_transfer();
        int n;
        @(posedge i_clk);
        i_wr_data <= 8'ha5;
        i_with_break <= 1'b1;
        i_read <= 1'b1;
        i_start <= 1'b1;
        @(posedge i_clk);
        i_start <= 1'b0;
        for (n = 0; n < 45000 && rx_cnt == 16'h0000; n++) @(posedge i_clk);
        check({8'h00, o_rx_data}, 16'h00a5);
        check(brk_cnt, 16'h0001);
        check({15'h0000, o_tx_ready}, 16'h0000);
        i_tx_data <= 8'h3c;
        i_tx_valid <= 1'b1;
        for (n = 0; n < 6000 && o_tx_busy !== 1'b1; n++) @(posedge i_clk);
        i_tx_valid <= 1'b0;
        check(16'(n >= 190 * 20 - 4 && n < 6000), 16'h0001);
        for (n = 0; n < 40000 && rd_cnt == 16'h0000; n++) @(posedge i_clk);
        check(rd_last, 16'h003c);
        check(tm_cnt, 16'h0000);
        for (n = 0; n < 6000 && o_ready !== 1'b1; n++) @(posedge i_clk);
        check({15'h0000, o_ready}, 16'h0001);
    endtask

    task automatic line_hold_reset();
        int n;
        i_hold_line <= 1'b1;
        for (n = 0; n < RST_CYC + 200 && lrst_cnt == 16'h0000; n++)
            @(posedge i_clk);
        i_hold_line <= 1'b0;
        check(lrst_cnt, 16'h0001);
        check(16'(n >= RST_CYC - 20 && n <= RST_CYC + 60), 16'h0001);
        repeat (400) @(posedge i_clk);
        check(brk_cnt, 16'h0002);
        check(rx_cnt, 16'h0001);
    endtask

    task automatic scl_hold_reset();
        int n;
        // a hold well short of the limit must leave the interface alone
        i_hold_scl <= 1'b1;
        repeat (RST_CYC / 3) @(posedge i_clk);
        i_hold_scl <= 1'b0;
        repeat (100) @(posedge i_clk);
        check(srst_cnt, 16'h0000);
        i_hold_scl <= 1'b1;
        for (n = 0; n < RST_CYC + 200 && srst_cnt == 16'h0000; n++)
            @(posedge i_clk);
        i_hold_scl <= 1'b0;
        check(srst_cnt, 16'h0001);
        check(16'(n >= RST_CYC - 20 && n <= RST_CYC + 60), 16'h0001);
        check(lrst_cnt, 16'h0001);
    endtask

    initial begin
        i_rst = 1'b1;
        {i_start, i_with_break, i_read, i_hold_line, i_hold_scl} = '0;
        i_wr_data = 8'h00;
        i_tx_data = 8'h00;
        i_tx_valid = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        run_transfer();
        line_hold_reset();
        scl_hold_reset();
        end_of_test();
    end

    // the full run needs about 4.3 ms
    initial begin
        #4_900_000;
        mismatches++;
        end_of_test();
    end
endmodule
